//--- hw/spf_pkg.sv
// Shared constants for the self-programming flash control block.
package spf_pkg;

    // Register map and field layout of the control/status register.
    localparam logic [11:0] CTRL_ADDR     = 12'h000;
    localparam int          CTRL_W        = 6;
    localparam int          BIT_ENABLE    = 0;
    localparam int          BIT_ERASE     = 1;
    localparam int          BIT_WRITE     = 2;
    localparam int          BIT_FUSE_RD   = 3;
    localparam int          BIT_CLR_BUF   = 4;
    localparam int          BIT_SIG_RD    = 5;
    localparam int          BIT_RWW_BUSY  = 6;
    localparam logic [5:0]  CTRL_RESET    = 6'h00;

    // Accepted command patterns in the lower six bits.
    localparam logic [5:0]  CMD_SIG_RD    = 6'h21;
    localparam logic [5:0]  CMD_CLR_BUF   = 6'h11;
    localparam logic [5:0]  CMD_FUSE_RD   = 6'h09;
    localparam logic [5:0]  CMD_PG_WRITE  = 6'h05;
    localparam logic [5:0]  CMD_PG_ERASE  = 6'h03;
    localparam logic [5:0]  CMD_BUF_LOAD  = 6'h01;

    // Arming windows in clock cycles after the register write.
    localparam logic [2:0]  ARM_STORE_CYC = 3'h4;
    localparam logic [2:0]  ARM_LOAD_CYC  = 3'h3;

    // Pointer addresses for fuse, lock and signature reads.
    localparam logic [15:0] Z_FUSE_LOW    = 16'h0000;
    localparam logic [15:0] Z_LOCK        = 16'h0001;
    localparam logic [15:0] Z_FUSE_EXT    = 16'h0002;
    localparam logic [15:0] Z_FUSE_HIGH   = 16'h0003;
    localparam logic [15:0] Z_SIG0        = 16'h0000;
    localparam logic [15:0] Z_RC_CAL      = 16'h0001;
    localparam logic [15:0] Z_SIG1        = 16'h0002;
    localparam logic [15:0] Z_TS_OFFSET   = 16'h0003;
    localparam logic [15:0] Z_SIG2        = 16'h0004;
    localparam logic [15:0] Z_TS_GAIN     = 16'h0005;
    localparam logic [7:0]  RESERVED_RD   = 8'h00;

    // Page organisation: word index and page number inside the pointer.
    localparam int          PAGE_WORDS    = 64;
    localparam int          WORD_LSB      = 1;
    localparam int          WORD_W        = 6;
    localparam int          PAGE_LSB      = 7;
    localparam int          PAGE_W        = 9;
    localparam int          BUF_W         = PAGE_WORDS * 16;

    // Flash programming time, minimum figure, rounded up to clock cycles.
    localparam int          CLK_MHZ       = 50;
    localparam int          PROG_MIN_US   = 3700;
    localparam int          PROG_CYC      = PROG_MIN_US * CLK_MHZ;
    localparam int          TMR_W         = 18;

endpackage

//--- hw/spf_op_if.sv
// Handshake between the command logic and the flash operation timer.
`timescale 1ns/1ns
interface spf_op_if;
    logic                        start;
    logic                        isErase;
    logic [spf_pkg::PAGE_W-1:0]  page;
    logic                        eraseOn;
    logic                        writeOn;
    logic [spf_pkg::PAGE_W-1:0]  busyPage;
    logic                        done;

    modport ctl (output start, isErase, page, input eraseOn, writeOn, busyPage, done);
    modport tmr (input start, isErase, page, output eraseOn, writeOn, busyPage, done);
endinterface

//--- hw/spf_op_timer.sv
// Flash erase and write timer; runs on power-on reset only.
`timescale 1ns/1ns
module spf_op_timer #(
    parameter int PROG_CYC = spf_pkg::PROG_CYC
) (
    input  wire logic clk,
    input  wire logic porSync_n,
    spf_op_if.tmr     op
);
    typedef struct packed {
        logic                            eraseOn;
        logic                            writeOn;
        logic [spf_pkg::PAGE_W-1:0]      page;
        logic [spf_pkg::TMR_W-1:0]       cnt;
        logic                            done;
    } spf_tmr_s;

    localparam logic [spf_pkg::TMR_W-1:0] LAST = spf_pkg::TMR_W'(PROG_CYC - 1);

    spf_tmr_s st_r;
    spf_tmr_s st_nxt;

    // A started operation counts out the full time; the system reset does not stop it.
    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (st_r.eraseOn || st_r.writeOn)
        begin
            if (st_r.cnt == LAST)
            begin
                st_nxt.eraseOn = 1'b0;
                st_nxt.writeOn = 1'b0;
                st_nxt.done    = 1'b1;
            end
            else
            begin
                st_nxt.cnt = st_r.cnt + 1'b1;
            end
        end
        else if (op.start)
        begin
            st_nxt.eraseOn = op.isErase;
            st_nxt.writeOn = !op.isErase;
            st_nxt.page    = op.page;
            st_nxt.cnt     = '0;
        end
    end

    // Only the power-on reset clears the timer so writes survive a system reset.
    always_ff @(posedge clk or negedge porSync_n)
    begin
        if (!porSync_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign op.eraseOn  = st_r.eraseOn;
    assign op.writeOn  = st_r.writeOn;
    assign op.busyPage = st_r.page;
    assign op.done     = st_r.done;
endmodule

//--- hw/spf_flash_ctrl.sv
// Self-programming control: command register, page buffer, special reads.
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module spf_flash_ctrl #(
    parameter int          PROG_CYC = spf_pkg::PROG_CYC,
    parameter logic [7:0]  SIG_BYTE0 = 8'h11, // Arbitrary identification value.
    parameter logic [7:0]  SIG_BYTE1 = 8'h22, // Arbitrary identification value.
    parameter logic [7:0]  SIG_BYTE2 = 8'h33  // Arbitrary identification value.
) (
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    input  wire logic                              por_n,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [11:0]                       paddr,
    input  wire logic [31:0]                       pwdata,
    output logic                                   pready,
    output logic [31:0]                            prdata,
    output logic                                   pslverr,
    input  wire logic                              spmStrobe,
    input  wire logic                              lpmStrobe,
    input  wire logic [15:0]                       zPtr,
    input  wire logic [15:0]                       spmData,
    input  wire logic                              eeprom_write_busy,
    input  wire logic [7:0]                        fuseLowProg,
    input  wire logic [7:0]                        fuseHighProg,
    input  wire logic [7:0]                        fuseExtProg,
    input  wire logic [7:0]                        lockProg,
    input  wire logic [7:0]                        rcCalByte,
    input  wire logic [7:0]                        temp_sensor_offset,
    input  wire logic [7:0]                        temp_sensor_gain,
    output logic                                   lpmOverride,
    output logic [7:0]                             lpmData,
    output logic                                   cpuHalt,
    output logic                                   flashEraseReq,
    output logic                                   flashWriteReq,
    output logic [spf_pkg::PAGE_W-1:0]             flashPage,
    output logic [spf_pkg::BUF_W-1:0]              pageBuffer
);
    typedef struct packed {
        logic [spf_pkg::CTRL_W-1:0]   ctrl;
        logic [2:0]                   armCnt;
        logic                         opWait;
        logic [spf_pkg::BUF_W-1:0]    buf_;
        logic [spf_pkg::PAGE_WORDS-1:0] loaded;
        logic                         lpmHit;
        logic [7:0]                   lpmData;
        logic                         halt;
        logic                         start;
        logic                         isErase;
        logic [spf_pkg::PAGE_W-1:0]   page;
        logic                         pready;
        logic [31:0]                  prdata;
        logic                         pslverr;
    } spf_state_s;

    spf_state_s       st_r;
    spf_state_s       st_nxt;
    logic [1:0]       rstSync_r;
    logic [1:0]       porSync_r;
    logic             rstQ_n;
    logic             apbAccess;
    logic             apbHit;
    logic             cmdValid;
    logic             opBusy;
    logic             lpmWindow;
    logic [7:0]       fuseByte;
    logic [7:0]       sigByte;
    logic [spf_pkg::WORD_W-1:0] wordIdx;

    spf_op_if opIf ();

    spf_op_timer #(
        .PROG_CYC (PROG_CYC)
    ) u_timer (
        .clk       (clk),
        .porSync_n (porSync_r[1]),
        .op        (opIf.tmr)
    );

    // Reset release through two flops for both system and power-on reset.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rstSync_r <= 2'h0;
        else
            rstSync_r <= {rstSync_r[0], 1'b1};
    end

    always_ff @(posedge clk or negedge por_n)
    begin
        if (!por_n)
            porSync_r <= 2'h0;
        else
            porSync_r <= {porSync_r[0], 1'b1};
    end

    assign rstQ_n = rstSync_r[1];

    // Decode helpers for the bus, pointer and special read sources.
    assign apbAccess = psel && penable && st_r.pready;
    assign apbHit    = paddr == spf_pkg::CTRL_ADDR;
    assign opBusy    = opIf.eraseOn || opIf.writeOn;
    assign wordIdx   = zPtr[spf_pkg::WORD_LSB +: spf_pkg::WORD_W];
    assign lpmWindow = st_r.armCnt > (spf_pkg::ARM_STORE_CYC - spf_pkg::ARM_LOAD_CYC);
    assign cmdValid  = pwdata[5:0] == spf_pkg::CMD_SIG_RD   ||
                       pwdata[5:0] == spf_pkg::CMD_CLR_BUF  ||
                       pwdata[5:0] == spf_pkg::CMD_FUSE_RD  ||
                       pwdata[5:0] == spf_pkg::CMD_PG_WRITE ||
                       pwdata[5:0] == spf_pkg::CMD_PG_ERASE ||
                       pwdata[5:0] == spf_pkg::CMD_BUF_LOAD;

    // Fuse and lock sources are returned inverted so programmed bits read zero.
    always_comb
    begin
        case (zPtr)
            spf_pkg::Z_FUSE_LOW:  fuseByte = ~fuseLowProg;
            spf_pkg::Z_LOCK:      fuseByte = ~lockProg;
            spf_pkg::Z_FUSE_EXT:  fuseByte = ~fuseExtProg;
            spf_pkg::Z_FUSE_HIGH: fuseByte = ~fuseHighProg;
            default:              fuseByte = spf_pkg::RESERVED_RD;
        endcase
    end

    // Signature row map.
    always_comb
    begin
        case (zPtr)
            spf_pkg::Z_SIG0:      sigByte = SIG_BYTE0;
            spf_pkg::Z_SIG1:      sigByte = SIG_BYTE1;
            spf_pkg::Z_SIG2:      sigByte = SIG_BYTE2;
            spf_pkg::Z_RC_CAL:    sigByte = rcCalByte;
            spf_pkg::Z_TS_OFFSET: sigByte = temp_sensor_offset;
            spf_pkg::Z_TS_GAIN:   sigByte = temp_sensor_gain;
            default:              sigByte = spf_pkg::RESERVED_RD;
        endcase
    end

    // Next-state logic: bus slave, arming window, store and load handling.
    always_comb
    begin
        st_nxt         = st_r;
        st_nxt.start   = 1'b0;
        st_nxt.lpmHit  = 1'b0;
        st_nxt.pready  = psel && penable && !st_r.pready;
        st_nxt.pslverr = 1'b0;

        // Arming window runs down and drops the whole command on expiry.
        if (st_r.armCnt != 3'h0)
        begin
            st_nxt.armCnt = st_r.armCnt - 3'h1;
            if (st_r.armCnt == 3'h1)
                st_nxt.ctrl = spf_pkg::CTRL_RESET;
        end

        // Store instruction inside the window consumes an armed command other than a fuse or signature read.
        if (spmStrobe && st_r.armCnt != 3'h0)
        begin
            case (st_r.ctrl)
                spf_pkg::CMD_BUF_LOAD:
                begin
                    if (!st_r.loaded[wordIdx])
                    begin
                        st_nxt.buf_[wordIdx*16 +: 16] = spmData;
                        st_nxt.loaded[wordIdx]        = 1'b1;
                    end
                    st_nxt.ctrl   = spf_pkg::CTRL_RESET;
                    st_nxt.armCnt = 3'h0;
                end
                spf_pkg::CMD_PG_ERASE,
                spf_pkg::CMD_PG_WRITE:
                begin
                    st_nxt.start   = 1'b1;
                    st_nxt.ctrl    = st_r.ctrl;
                    st_nxt.isErase = st_r.ctrl[spf_pkg::BIT_ERASE];
                    st_nxt.page    = zPtr[spf_pkg::PAGE_LSB +: spf_pkg::PAGE_W];
                    st_nxt.halt    = 1'b1;
                    st_nxt.opWait  = 1'b1;
                    st_nxt.armCnt  = 3'h0;
                end
                spf_pkg::CMD_CLR_BUF:
                begin
                    st_nxt.ctrl   = spf_pkg::CTRL_RESET;
                    st_nxt.armCnt = 3'h0;
                end
                default:
                begin
                    // A store during a read command has no effect; the window still runs out.
                end
            endcase
        end

        // Load instruction inside the shorter window returns a special byte.
        if (lpmStrobe && lpmWindow &&
            (st_r.ctrl == spf_pkg::CMD_FUSE_RD || st_r.ctrl == spf_pkg::CMD_SIG_RD))
        begin
            st_nxt.lpmHit  = 1'b1;
            st_nxt.lpmData = st_r.ctrl[spf_pkg::BIT_SIG_RD] ? sigByte : fuseByte;
            st_nxt.ctrl    = spf_pkg::CTRL_RESET;
            st_nxt.armCnt  = 3'h0;
        end

        // End of erase or write releases the CPU and the command bits.
        if (st_r.opWait && opIf.done)
        begin
            st_nxt.opWait = 1'b0;
            st_nxt.halt   = 1'b0;
            st_nxt.ctrl   = spf_pkg::CTRL_RESET;
            if (!st_r.isErase)
            begin
                st_nxt.buf_   = '0;
                st_nxt.loaded = '0;
            end
        end

        // An EEPROM write during page loading loses the loaded data.
        if (eeprom_write_busy && st_r.loaded != '0)
        begin
            st_nxt.buf_   = '0;
            st_nxt.loaded = '0;
        end

        // Bus access: register write arms a command, read shows live status.
        if (st_nxt.pready)
        begin
            st_nxt.prdata = '0;
            st_nxt.pslverr = !apbHit;
            if (apbHit && !pwrite)
            begin
                st_nxt.prdata[spf_pkg::CTRL_W-1:0]     = st_r.ctrl;
                st_nxt.prdata[spf_pkg::BIT_ENABLE]     = st_r.ctrl[spf_pkg::BIT_ENABLE] ||
                                                         opBusy;
                st_nxt.prdata[spf_pkg::BIT_RWW_BUSY]   = 1'b0;
            end
        end
        if (apbAccess && apbHit && pwrite && cmdValid &&
            !eeprom_write_busy &&
            !st_r.opWait && !opBusy)
        begin
            st_nxt.ctrl   = pwdata[spf_pkg::CTRL_W-1:0];
            st_nxt.armCnt = spf_pkg::ARM_STORE_CYC;
            if (pwdata[5:0] == spf_pkg::CMD_CLR_BUF)
            begin
                st_nxt.buf_   = '0;
                st_nxt.loaded = '0;
            end
        end
    end

    // State register on the released system reset; page buffer clears too.
    always_ff @(posedge clk or negedge rstQ_n)
    begin
        if (!rstQ_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign opIf.start   = st_r.start;
    assign opIf.isErase = st_r.isErase;
    assign opIf.page    = st_r.page;

    // Outputs straight from flops.
    assign pready        = st_r.pready;
    assign prdata        = st_r.prdata;
    assign pslverr       = st_r.pslverr;
    assign lpmOverride   = st_r.lpmHit;
    assign lpmData       = st_r.lpmData;
    assign cpuHalt       = st_r.halt;
    assign flashEraseReq = opIf.eraseOn;
    assign flashWriteReq = opIf.writeOn;
    assign flashPage     = opIf.busyPage;
    assign pageBuffer    = st_r.buf_;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstQ_n);

    a_arm_window_len: assert property (
        apbAccess && pwrite && apbHit && cmdValid && !eeprom_write_busy && !opBusy
        && !st_r.opWait |=> st_r.armCnt == 3'h4)
        else $error("arming window not loaded with four cycles");

    a_enable_timeout: assert property (
        st_r.armCnt == 3'h1 && !spmStrobe && !lpmStrobe && !apbAccess |=>
        st_r.ctrl == 6'h00)
        else $error("enable bit survived an expired window");

    a_busy_reads_high: assert property (
        opBusy && st_nxt.pready && apbHit && !pwrite |=> prdata[0])
        else $error("enable bit read low during erase or write");

    a_bad_cmd_ignored: assert property (
        apbAccess && pwrite && !cmdValid && st_r.armCnt == 3'h0 && !st_r.opWait
        |=> st_r.ctrl == $past(st_r.ctrl))
        else $error("invalid command pattern changed the register");

    a_eeprom_blocks: assert property (
        apbAccess && pwrite && eeprom_write_busy && st_r.armCnt == 3'h0 && !st_r.opWait
        |=> st_r.armCnt == 3'h0)
        else $error("command armed during EEPROM write");

    a_lock_read_value: assert property (
        lpmStrobe && lpmWindow && st_r.ctrl == 6'h09 && zPtr == 16'h0001
        |=> lpmOverride && lpmData == ~$past(lockProg) ##1 !lpmOverride)
        else $error("lock byte not returned");

    a_sig_byte_zero: assert property (
        lpmStrobe && lpmWindow && st_r.ctrl == 6'h21 && zPtr == 16'h0000
        |=> lpmData == SIG_BYTE0 && st_r.ctrl == 6'h00)
        else $error("signature byte zero not returned");

    a_plain_lpm: assert property (
        lpmStrobe && st_r.ctrl == 6'h00 |=> !lpmOverride)
        else $error("special read without armed command");

    a_rww_zero: assert property (
        pready |-> !prdata[6] && !prdata[7])
        else $error("reserved or busy flag read nonzero");

    a_page_write_halt: assert property (
        opIf.writeOn && st_r.opWait |-> cpuHalt && st_r.ctrl == spf_pkg::CMD_PG_WRITE)
        else $error("CPU not halted or command dropped during page write");
endmodule

//--- verif/spf_cpu_model.sv
// CPU-side model issuing store and load strobes with pointer and data.
`timescale 1ns/1ns
module spf_cpu_model (
    input  wire logic        clk,
    output logic             spmStrobe,
    output logic             lpmStrobe,
    output logic [15:0]      zPtr,
    output logic [15:0]      spmData
);
    // Idle state; pointer and data are inverted so stale values never look valid.
    initial
    begin
        spmStrobe = 1'b0;
        lpmStrobe = 1'b0;
        zPtr      = 16'hFFFF;
        spmData   = 16'hFFFF;
    end

    // Issues one instruction after a wait and finishes it before returning.
    task automatic issue(input logic st, input int w, input logic [15:0] z,
                         input logic [15:0] d);
        repeat (w) @(posedge clk);
        zPtr      <= z;
        spmData   <= d;
        spmStrobe <= st;
        lpmStrobe <= !st;
        @(posedge clk);
        spmStrobe <= 1'b0;
        lpmStrobe <= 1'b0;
        zPtr      <= ~z;
        spmData   <= ~d;
    endtask
endmodule

//--- verif/tb_self_program_flash_control.sv
// Self-checking bench for the self-programming flash control block.
`timescale 1ns/1ns
module tb_self_program_flash_control;
    localparam int         PCYC = 20;
    localparam logic [7:0] SIG0 = 8'hA5; // Arbitrary identification value.
    localparam logic [7:0] SIG1 = 8'h5A; // Arbitrary identification value.
    localparam logic [7:0] SIG2 = 8'h3C; // Arbitrary identification value.
    logic          clk, rst_n, porN, psel, penable, pwrite, pready, pslverr, eeBusy;
    logic          spm, lpm, lpmOverride, cpuHalt, eraseReq, writeReq, rdErr;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, rdVal;
    logic [15:0]   zPtr, spmData, z, d;
    logic [7:0]    fl, fh, fe, lk, rc, tso, tsg, lpmData;
    logic [7:0]    sigExp [7];
    logic [8:0]    flashPage, p;
    logic [1023:0] pageBuffer;
    int            errTotal, checksDone, opCyc, opBase, n;

    spf_flash_ctrl #(.PROG_CYC(PCYC), .SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1),
        .SIG_BYTE2(SIG2)) DUT (.clk(clk), .rst_n(rst_n), .por_n(porN), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .spmStrobe(spm),
        .lpmStrobe(lpm), .zPtr(zPtr), .spmData(spmData), .eeprom_write_busy(eeBusy),
        .fuseLowProg(fl), .fuseHighProg(fh), .fuseExtProg(fe), .lockProg(lk),
        .rcCalByte(rc), .temp_sensor_offset(tso), .temp_sensor_gain(tsg),
        .lpmOverride(lpmOverride), .lpmData(lpmData), .cpuHalt(cpuHalt),
        .flashEraseReq(eraseReq), .flashWriteReq(writeReq), .flashPage(flashPage),
        .pageBuffer(pageBuffer));
    spf_cpu_model cpu (.clk(clk), .spmStrobe(spm), .lpmStrobe(lpm), .zPtr(zPtr),
        .spmData(spmData));

    // Clock and a count of cycles that a flash operation is requested.
    always #10 clk = ~clk;
    always @(posedge clk) opCyc <= opCyc + int'(eraseReq === 1'b1 || writeReq === 1'b1);

    // Compares one result against the model value.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            errTotal++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic tally_and_finish();
        $display("errors=%0d checks=%0d", errTotal, checksDone);
        if (errTotal == 0 && checksDone > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One APB transfer; waits for ready and keeps read data and error.
    task automatic apb(input logic w, input logic [31:0] dat);
        @(posedge clk); // Idle cycle so back-to-back calls never drive psel twice at once.
        psel    <= 1'b1;
        pwrite  <= w;
        pwdata  <= dat;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rdVal   = prdata;
        rdErr   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Issues a load and checks whether a special byte replaced the flash read.
    task automatic lpm_chk(input int w, input logic [15:0] a, input logic [7:0] e,
                           input logic hit);
        cpu.issue(1'b0, w, a, 16'h0000);
        #1;
        for (n = 0; n < 3 && lpmOverride !== 1'b1; n++)
            @(posedge clk) #1;
        chk(32'(lpmOverride), 32'(hit));
        if (hit)
            chk(32'(lpmData), 32'(e));
        @(posedge clk);
    endtask

    // Watchdog against a hung handshake.
    initial
    begin
        repeat (20000) @(posedge clk);
        errTotal++;
        tally_and_finish();
    end

    // Main sequence.
    initial
    begin
        clk = 0; rst_n = 0; porN = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = spf_pkg::CTRL_ADDR; pwdata = 0; eeBusy = 0; opCyc = 0;
        n = $urandom(32'hBD786295);
        {fl, fh, fe, lk, rc, tso, tsg} = 56'({$urandom, $urandom});
        sigExp = '{SIG0, rc, SIG1, tso, SIG2, tsg, spf_pkg::RESERVED_RD};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        porN  <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, 0);
        chk(rdVal, 32'h0);
        paddr <= 12'h004;
        apb(1'b0, 0);
        chk(32'(rdErr), 32'h1);
        paddr <= spf_pkg::CTRL_ADDR;
        for (int k = 0; k < 5; k++)
        begin
            z = {9'($urandom), 6'(k * 10), 1'b1};
            d = 16'($urandom);
            apb(1'b1, 32'(spf_pkg::CMD_BUF_LOAD));
            cpu.issue(1'b1, k, z, d);
            @(posedge clk);
            apb(1'b0, 0);
            chk(rdVal, 32'h0);
            chk(32'(pageBuffer[k * 160 +: 16]), (k < 4) ? 32'(d) : 32'h0);
        end
        foreach (sigExp[k])
        begin
            apb(1'b1, {26'($urandom), 6'h07 + 6'(k * 6)});
            cpu.issue(1'b1, 0, {9'h0, 6'd63, 1'b0}, 16'hBEEF);
            apb(1'b0, 0);
            chk(rdVal | 32'(pageBuffer[1008 +: 16]), 32'h0);
        end
        apb(1'b1, 32'(spf_pkg::CMD_CLR_BUF));
        @(posedge clk);
        chk(32'(|pageBuffer), 32'h0);
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b1, 32'(spf_pkg::CMD_FUSE_RD));
            lpm_chk(k % 3, 16'(k), ~(k == 0 ? fl : k == 1 ? lk : k == 2 ? fe : fh), 1'b1);
            apb(1'b0, 0);
            chk(rdVal, 32'h0);
        end
        foreach (sigExp[k])
        begin
            apb(1'b1, 32'(spf_pkg::CMD_SIG_RD));
            lpm_chk(2, 16'(k), sigExp[k], 1'b1);
        end
        apb(1'b1, 32'(spf_pkg::CMD_SIG_RD));
        lpm_chk(3, 16'h0001, 8'h00, 1'b0);
        lpm_chk(0, 16'h0001, 8'h00, 1'b0);
        eeBusy <= 1'b1;
        apb(1'b1, 32'(spf_pkg::CMD_FUSE_RD));
        lpm_chk(0, 16'h0001, 8'h00, 1'b0);
        apb(1'b1, 32'(spf_pkg::CMD_PG_ERASE));
        cpu.issue(1'b1, 0, 16'h0080, 16'h0000);
        apb(1'b0, 0);
        chk(rdVal | 32'(cpuHalt), 32'h0);
        eeBusy <= 1'b0;
        p = 9'($urandom);
        opBase = opCyc;
        apb(1'b1, 32'(spf_pkg::CMD_PG_ERASE));
        cpu.issue(1'b1, 3, {p, 7'h00}, 16'h0000);
        apb(1'b0, 0);
        chk(rdVal, 32'(spf_pkg::CMD_PG_ERASE));
        chk(32'({cpuHalt, eraseReq, flashPage}), 32'({2'b11, p}));
        for (n = 0; n < 200 && cpuHalt !== 1'b0; n++)
            @(posedge clk);
        chk(32'(opCyc - opBase), 32'(PCYC));
        apb(1'b1, 32'(spf_pkg::CMD_BUF_LOAD));
        cpu.issue(1'b1, 0, {p, 7'h0A}, 16'h1234);
        opBase = opCyc;
        apb(1'b1, 32'(spf_pkg::CMD_PG_WRITE));
        cpu.issue(1'b1, 1, {p, 7'h00}, 16'h0000);
        repeat (2) @(posedge clk);
        chk(32'({cpuHalt, writeReq, flashPage}), 32'({2'b11, p}));
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk(32'(writeReq), 32'h1);
        for (n = 0; n < 200 && writeReq !== 1'b0; n++)
            @(posedge clk);
        chk(32'(opCyc - opBase), 32'(PCYC));
        chk(32'(pageBuffer[80 +: 16]), 32'h0);
        tally_and_finish();
    end
endmodule
